//--- rtl/pfs_fault_select.sv
// Purpose: fault source selection for pulse_modulator 0
// Assumes: all inputs synchronous to clk
// Notes: fault outputs registered, one cycle after the sources
//
// Summary of operation
// - out-register bits 30..27 admit digital comparators 3..0 for output B.
// - out-register bits 26..23 admit external faults 3..0 for output B.
// - out-register bits 22..16 admit analog comparators G..A for output B.
// - out-register bits 14..11 admit digital comparators 3..0 for output A.
// - out-register bits 10..7 admit external faults 3..0 for output A.
// - out-register bits 6..0 admit analog comparators G..A for output A.
// - all enable bits of both registers reset to zero.
// - A/B register holds 15 read-write enables at bits 14..0, reset zero.
// - a digital comparator faults only after its programmed sample count.
`timescale 1ns/1ps
`include "pfs_defs.svh"
module pfs_fault_select
  import pfs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [23:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // fault sources
  input wire logic [3:0] dig_cmp_valid,
  input wire logic [3:0] dig_cmp_hit,
  input wire logic [3:0] ext_flt,
  input wire logic [6:0] ana_cmp,
  // fault results
  output logic fault_ab,
  output logic fault_a,
  output logic fault_b,
  output logic irq
);
  logic [31:0] ab_en;
  logic [31:0] out_en;
  logic [31:0] cnt_lim;
  logic [31:0] cnt_clr;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [3:0] dig_fault;
  logic [31:0] cnt_stat;
  pfs_src_t src;
  logic next_ab;
  logic next_a;
  logic next_b;
  logic [31:0] next_rdata;

  // one detection counter per digital comparator
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_det
      pfs_det_if det ();
      assign det.sample_valid = dig_cmp_valid[gi];
      assign det.sample_hit = dig_cmp_hit[gi];
      assign det.clear = cnt_clr[gi];
      assign det.limit = cnt_lim[8*gi +: 8];
      assign dig_fault[gi] = det.fault;
      assign cnt_stat[8*gi +: 8] = det.count;
      pfs_det_counter u_cnt (
        .clk(clk),
        .sys_rst(sys_rst),
        .det(det)
      );
    end
  endgenerate

  // clear pulse: write of a one to bits 3..0 of the count status register, one bit per counter
  assign cnt_clr = {28'h0000000,
    {4{reg_wr && reg_addr == `PFS_OFS_DCNT_STAT}} & reg_wdata[3:0]};

  // source vector in register order: dig 3..0, ext 3..0, ana G..A
  assign src = {dig_fault, ext_flt, ana_cmp};

  // masked OR of the enabled sources
  always_comb begin
    next_ab = |(src & ab_en[14:0]);
    next_a = |(src & out_en[14:0]);
    next_b = |(src & out_en[`PFS_OUTB_LSB +: 15]);
  end

  // registered fault outputs, evaluated every cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_ab <= 1'b0;
      fault_a <= 1'b0;
      fault_b <= 1'b0;
    end else begin
      fault_ab <= next_ab;
      fault_a <= next_a;
      fault_b <= next_b;
    end
  end

  // enable, limit and mask registers; reserved bits never store
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ab_en <= `PFS_EN_RST;
      out_en <= `PFS_EN_RST;
      cnt_lim <= `PFS_LIM_RST;
      irq_mask <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == `PFS_OFS_AB_EN) begin
        ab_en <= reg_wdata & `PFS_AB_MASK;
      end
      if (reg_addr == `PFS_OFS_OUT_EN) begin
        out_en <= reg_wdata & `PFS_OUT_MASK;
      end
      if (reg_addr == `PFS_OFS_DCNT_LIM) begin
        cnt_lim <= reg_wdata;
      end
      if (reg_addr == `PFS_OFS_IRQ_MASK) begin
        irq_mask <= reg_wdata[2:0];
      end
    end
  end

  // sticky status on rising fault; set wins over write-one clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~({3{reg_wr &&
        reg_addr == `PFS_OFS_IRQ_STAT}} & reg_wdata[2:0])) |
        ({next_b, next_a, next_ab} & ~{fault_b, fault_a, fault_ab});
    end
  end

  // level interrupt from masked status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    unique case (reg_addr)
      `PFS_OFS_AB_EN: next_rdata = ab_en;
      `PFS_OFS_OUT_EN: next_rdata = out_en;
      `PFS_OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
      `PFS_OFS_IRQ_MASK: next_rdata = {29'h0, irq_mask};
      `PFS_OFS_DCNT_LIM: next_rdata = cnt_lim;
      `PFS_OFS_DCNT_STAT: next_rdata = cnt_stat;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // checks
  property p_b_dig;
    @(posedge clk) disable iff (sys_rst)
      (out_en[30:27] & dig_fault) != 4'h0 |=> fault_b;
  endproperty
  a_b_dig: assert property (p_b_dig) else $error("b dig lost");
  property p_b_ext;
    @(posedge clk) disable iff (sys_rst)
      (out_en[26:23] & ext_flt) != 4'h0 |=> fault_b;
  endproperty
  a_b_ext: assert property (p_b_ext) else $error("b ext lost");
  property p_b_ana;
    @(posedge clk) disable iff (sys_rst)
      (out_en[22:16] & ana_cmp) != 7'h00 |=> fault_b;
  endproperty
  a_b_ana: assert property (p_b_ana) else $error("b ana lost");
  property p_a_dig;
    @(posedge clk) disable iff (sys_rst)
      (out_en[14:11] & dig_fault) != 4'h0 |=> fault_a;
  endproperty
  a_a_dig: assert property (p_a_dig) else $error("a dig lost");
  property p_a_ext;
    @(posedge clk) disable iff (sys_rst)
      (out_en[10:7] & ext_flt) != 4'h0 |=> fault_a;
  endproperty
  a_a_ext: assert property (p_a_ext) else $error("a ext lost");
  property p_a_ana;
    @(posedge clk) disable iff (sys_rst)
      (out_en[6:0] & ana_cmp) != 7'h00 |=> fault_a;
  endproperty
  a_a_ana: assert property (p_a_ana) else $error("a ana lost");
  property p_rst_zero;
    @(posedge clk) $fell(sys_rst) |-> ab_en == 32'h0 && out_en == 32'h0;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("enables set");
  property p_ab_rw;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == `PFS_OFS_AB_EN ##1 reg_rd &&
      reg_addr == `PFS_OFS_AB_EN |=>
      reg_rdata == {17'h0, $past(reg_wdata[14:0], 2)};
  endproperty
  a_ab_rw: assert property (p_ab_rw) else $error("ab readback");
  property p_dig_gate;
    @(posedge clk) disable iff (sys_rst)
      dig_cmp_valid[0] && !dig_cmp_hit[0] && !cnt_clr[0] |=> !dig_fault[0];
  endproperty
  a_dig_gate: assert property (p_dig_gate) else $error("miss kept");
  property p_none;
    @(posedge clk) disable iff (sys_rst)
      (src & (ab_en[14:0] | out_en[14:0] | out_en[30:16])) == 15'h0
      |=> !fault_ab && !fault_a && !fault_b;
  endproperty
  a_none: assert property (p_none) else $error("spurious fault");
  // reserved enable bits must never be seen set
  property p_ab_rsv;
    @(posedge clk) disable iff (sys_rst)
      ab_en[31:15] == 17'h00000;
  endproperty
  a_ab_rsv: assert property (p_ab_rsv) else $error("ab reserved");
  property p_out_rsv;
    @(posedge clk) disable iff (sys_rst)
      out_en[31] == 1'b0 && out_en[15] == 1'b0;
  endproperty
  a_out_rsv: assert property (p_out_rsv) else $error("out reserved");
  // a software clear drops the comparator fault and its count on the next cycle
  property p_cnt_clr;
    @(posedge clk) disable iff (sys_rst)
      cnt_clr[0] |=> !dig_fault[0] && cnt_stat[7:0] == 8'h00;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("clear lost");
  // read data stand only in the cycle after a read strobe
  property p_rd_idle;
    @(posedge clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata stale");
  // an ab source alone raises the ab output next cycle
  property p_ab_src;
    @(posedge clk) disable iff (sys_rst)
      (src & ab_en[14:0]) != 15'h0000 |=> fault_ab;
  endproperty
  a_ab_src: assert property (p_ab_src) else $error("ab lost");
endmodule : pfs_fault_select

//--- rtl/pfs_defs.svh
// Purpose: offsets, field positions and reset values of the fault selector
// Assumes: included by bare name
// Notes: definitions only
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH
`define PFS_ADDR_W 24
`define PFS_OFS_AB_EN 24'h130038
`define PFS_OFS_OUT_EN 24'h13003c
`define PFS_OFS_IRQ_STAT 24'h130050
`define PFS_OFS_IRQ_MASK 24'h130054
`define PFS_OFS_DCNT_LIM 24'h130058
`define PFS_OFS_DCNT_STAT 24'h13005c
`define PFS_AB_MASK 32'h00007fff
`define PFS_OUT_MASK 32'h7fff7fff
`define PFS_OUTB_LSB 16
`define PFS_EN_RST 32'h00000000
`define PFS_LIM_RST 32'h00000000
`define PFS_IRQ_W 3
`endif

//--- rtl/pfs_pkg.sv
// Purpose: shared types of the fault selector
// Assumes: nothing
// Notes: one source set is 4 digital, 4 external, 7 analog
package pfs_pkg;
  typedef logic [14:0] pfs_src_t;
  typedef logic [7:0] pfs_cnt_t;
endpackage : pfs_pkg

//--- rtl/pfs_if.sv
// Purpose: carries a comparator sample and its qualified fault
// Assumes: one clock
// Notes: shared by top and counter instances
`timescale 1ns/1ps
interface pfs_det_if;
  import pfs_pkg::*;
  logic sample_valid;
  logic sample_hit;
  logic clear;
  pfs_cnt_t limit;
  pfs_cnt_t count;
  logic fault;
  modport ctl (output sample_valid, sample_hit, clear, limit,
    input count, fault);
  modport cnt (input sample_valid, sample_hit, clear, limit,
    output count, fault);
endinterface : pfs_det_if

//--- rtl/pfs_det_counter.sv
// Purpose: detection counter for one digital comparator
// Assumes: samples synchronous to clk
// Notes: a miss clears the counter
`timescale 1ns/1ps
module pfs_det_counter
  import pfs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // detection link
  pfs_det_if.cnt det
);
  // count hits; fault once the limit is reached
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      det.count <= 8'h00;
      det.fault <= 1'b0;
    end else if (det.clear) begin
      det.count <= 8'h00;
      det.fault <= 1'b0;
    end else if (det.sample_valid) begin
      if (det.sample_hit) begin
        if (det.count != 8'hff) begin
          det.count <= det.count + 8'h01;
        end
        // fault only after limit samples received
        // nine bits so a saturated count still compares as 256
        det.fault <= ({1'b0, det.count} + 9'h001) >= {1'b0, det.limit};
      end else begin
        det.count <= 8'h00; // a miss restarts the run
        det.fault <= 1'b0;
      end
    end
  end
endmodule : pfs_det_counter

//--- verif/pfs_src_model.sv
// Purpose: model of the comparators and fault pins
// Assumes: bench sets levels and sample pulses
// Notes: hit is junk between samples and never held steady
`timescale 1ns/1ps
module pfs_src_model
  import pfs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // requests from the bench
  input wire pfs_src_t want,
  input wire logic [3:0] pulse,
  // source outputs
  output logic [3:0] dig_cmp_valid,
  output logic [3:0] dig_cmp_hit,
  output logic [3:0] ext_flt,
  output logic [6:0] ana_cmp
);
  // levels follow the request one cycle late, like a synchroniser
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {dig_cmp_valid, dig_cmp_hit, ext_flt, ana_cmp} <= '0;
    end else begin
      ext_flt <= want[10:7];
      ana_cmp <= want[6:0];
      dig_cmp_valid <= pulse;
      // toggling hit exposes any use of it without valid
      dig_cmp_hit <= (pulse & want[14:11]) | (~pulse & ~dig_cmp_hit);
    end
  end
endmodule : pfs_src_model

//--- verif/test_pfs_fault_select.sv
// Purpose: self-checking bench of the fault selector
// Assumes: source model in front of the source inputs
// Notes: fault outputs are levels, checked after settling
`timescale 1ns/1ps
`include "pfs_defs.svh"
module test_pfs_fault_select
  import pfs_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [23:0] reg_addr = 24'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  pfs_src_t want = '0;
  logic [3:0] pulse = 4'h0;
  logic [31:0] reg_rdata;
  logic [3:0] dig_cmp_valid, dig_cmp_hit, ext_flt;
  logic [6:0] ana_cmp;
  logic fault_ab, fault_a, fault_b, irq;
  int fails = 0;
  int cmp_count = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  pfs_src_model i_src (.clk(clk), .sys_rst(sys_rst), .want(want),
    .pulse(pulse), .dig_cmp_valid(dig_cmp_valid),
    .dig_cmp_hit(dig_cmp_hit), .ext_flt(ext_flt), .ana_cmp(ana_cmp));
  pfs_fault_select i_dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dig_cmp_valid(dig_cmp_valid), .dig_cmp_hit(dig_cmp_hit),
    .ext_flt(ext_flt), .ana_cmp(ana_cmp), .fault_ab(fault_ab),
    .fault_a(fault_a), .fault_b(fault_b), .irq(irq));

  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the read edge
  task automatic rd(input logic [23:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask : rd
  // {fault_ab, fault_a, fault_b} once model and register stages settle
  task automatic outs(input logic [2:0] e);
    repeat (4) @(posedge clk);
    #1 chk("faults", {29'h0, e}, {29'h0, fault_ab, fault_a, fault_b});
  endtask : outs
  task automatic samp(input logic [3:0] m, input pfs_src_t h);
    @(posedge clk);
    want <= h;
    pulse <= m;
    @(posedge clk);
    pulse <= 4'h0;
  endtask : samp
  task automatic finish_test;
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic regs_test;
    rd(`PFS_OFS_AB_EN, 32'h0);
    rd(`PFS_OFS_OUT_EN, 32'h0);
    outs(3'h0);
    wr(`PFS_OFS_AB_EN, 32'hffffffff);
    rd(`PFS_OFS_AB_EN, 32'h00007fff);
    wr(`PFS_OFS_OUT_EN, 32'hffffffff);
    rd(`PFS_OFS_OUT_EN, 32'h7fff7fff);
    rd(24'h130040, 32'h0);
  endtask : regs_test
  // each pin and analog source alone, routed to A only, then to A/B and B
  task automatic route_test;
    for (int i = 0; i < 11; i++) begin
      wr(`PFS_OFS_AB_EN, 32'h7fff & ~(32'h1 << i));
      wr(`PFS_OFS_OUT_EN, 32'h1 << i);
      want <= 15'h1 << i;
      outs(3'b010);
      wr(`PFS_OFS_AB_EN, 32'h1 << i);
      wr(`PFS_OFS_OUT_EN, 32'h1 << (16 + i));
      outs(3'b101);
      want <= '0;
      outs(3'h0);
    end
  endtask : route_test
  // comparator 3 needs three hits, comparator 0 faults on the first
  task automatic digital_test;
    wr(`PFS_OFS_AB_EN, 32'h0);
    wr(`PFS_OFS_DCNT_LIM, 32'h03000000);
    wr(`PFS_OFS_OUT_EN, 32'h40000800);
    for (int i = 0; i < 2; i++) begin
      samp(4'h8, 15'h4000);
      outs(3'h0);
    end
    samp(4'h8, 15'h4000);
    outs(3'b001);
    samp(4'h1, 15'h0800);
    outs(3'b011);
    samp(4'h8, 15'h0);
    outs(3'b010);
    rd(`PFS_OFS_DCNT_STAT, 32'h00000001);
    wr(`PFS_OFS_DCNT_STAT, 32'h1);
    outs(3'h0);
    rd(`PFS_OFS_DCNT_STAT, 32'h0);
  endtask : digital_test
  task automatic irq_test;
    wr(`PFS_OFS_IRQ_STAT, 32'h7);
    wr(`PFS_OFS_IRQ_MASK, 32'h2);
    rd(`PFS_OFS_IRQ_STAT, 32'h0);
    samp(4'h1, 15'h0);
    wr(`PFS_OFS_IRQ_MASK, 32'h0);
    samp(4'h1, 15'h0800);
    outs(3'b010);
    rd(`PFS_OFS_IRQ_STAT, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`PFS_OFS_IRQ_MASK, 32'h2);
    outs(3'b010);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`PFS_OFS_IRQ_STAT, 32'h2);
    outs(3'b010);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : irq_test

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    regs_test();
    route_test();
    digital_test();
    irq_test();
    finish_test();
  end
endmodule : test_pfs_fault_select
